// ===== hdl/rtcm_ctrl.sv
// Control register, 32-bit counter and time-event logic of the RTC, behind an APB slave.
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/10ps
`include "rtcm_params.svh"
module rtcm_ctrl #(
    parameter int CNT_W = 32
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic aux_clock_in,
    input wire logic submain_clock_in,
    input wire logic second_prescaler_out,
    input wire logic first_prescaler_hold,
    input wire logic second_prescaler_hold,
    input wire rtcm_pkg::rtcm_cal_evt_t cal_evt,
    input wire logic cal_busy,
    output logic format_decimal_select,
    output logic cal_field_reset,
    output logic prescaler_clear,
    output logic first_prescaler_run,
    output logic second_prescaler_run,
    output logic calendar_tick,
    output logic time_event,
    output logic irq
);

    initial begin
        if (CNT_W != 32) begin
            $error("rtcm_ctrl serves only a 32-bit counter");
        end
    end

    rtcm_pkg::rtcm_ctl_t ctl_r;
    rtcm_pkg::rtcm_ctl_t ctl_nxt;
    rtcm_pkg::rtcm_irq_t stat_r;
    rtcm_pkg::rtcm_irq_t mask_r;
    logic [CNT_W-1:0] cnt_r;
    logic rdy_r;
    logic [2:0] src_in;
    logic [2:0] src_edge;
    logic [31:0] rd_mux;
    logic wr_acc;
    logic ctl_wr;
    logic cnt_wr;
    logic mode_chg;
    logic fmt_chg;
    logic sel_edge;
    logic cnt_tick;
    logic ovf_hit;
    logic cal_hit;
    logic tev_nxt;
    logic rdy_rise;

    // Clock inputs come from other domains; each is synchronised, then edge detected.
    assign src_in = {second_prescaler_out, submain_clock_in, aux_clock_in};

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_sync
            logic meta_r;
            logic sync_r;
            logic last_r;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    meta_r <= 1'b0;
                    sync_r <= 1'b0;
                    last_r <= 1'b0;
                end else begin
                    meta_r <= src_in[g];
                    sync_r <= meta_r;
                    last_r <= sync_r;
                end
            end
            assign src_edge[g] = sync_r & ~last_r;
        end
    endgenerate

    assign pready = 1'b1;
    assign wr_acc = psel & penable & pwrite;
    assign ctl_wr = wr_acc & (paddr == `RTCM_CTL1_OFS);
    assign cnt_wr = wr_acc & (paddr == `RTCM_COUNT_OFS);

    always_comb begin
        ctl_nxt = ctl_r;
        if (ctl_wr) begin
            ctl_nxt = rtcm_pkg::rtcm_ctl_t'(pwdata[7:0]);
            ctl_nxt.rdy = ctl_r.rdy;
        end
    end

    // Only an actual change of the stored bit counts as a switch.
    assign mode_chg = ctl_wr & (ctl_nxt.mode != ctl_r.mode);
    assign fmt_chg = ctl_wr & (ctl_nxt.fmt != ctl_r.fmt);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_r <= rtcm_pkg::rtcm_ctl_t'(`RTCM_CTL1_RST);
        end else begin
            ctl_r <= ctl_nxt;
        end
    end

    // Calendar always runs from the second prescaler; the source field is for counter mode.
    always_comb begin
        unique case (ctl_r.ssel)
            `RTCM_SRC_AUX: sel_edge = src_edge[0];
            `RTCM_SRC_SUB: sel_edge = src_edge[1];
            default: sel_edge = src_edge[2];
        endcase
    end

    assign cnt_tick = ~ctl_r.mode & ~ctl_r.hold & sel_edge;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= `RTCM_COUNT_RST;
        end else if (mode_chg) begin
            cnt_r <= `RTCM_COUNT_RST;
        end else if (cnt_wr) begin
            cnt_r <= pwdata;
        end else if (cnt_tick) begin
            cnt_r <= cnt_r + 32'h0000_0001;
        end
    end

    always_comb begin
        unique case (ctl_r.tev)
            `RTCM_TEV_8: ovf_hit = &cnt_r[7:0];
            `RTCM_TEV_16: ovf_hit = &cnt_r[15:0];
            `RTCM_TEV_24: ovf_hit = &cnt_r[23:0];
            default: ovf_hit = &cnt_r;
        endcase
        unique case (ctl_r.tev)
            `RTCM_TEV_8: cal_hit = cal_evt.minute;
            `RTCM_TEV_16: cal_hit = cal_evt.hour;
            `RTCM_TEV_24: cal_hit = cal_evt.midnight;
            default: cal_hit = cal_evt.noon;
        endcase
    end

    assign tev_nxt = ctl_r.mode ? cal_hit : (cnt_tick & ovf_hit & ~cnt_wr & ~mode_chg);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            time_event <= 1'b0;
            cal_field_reset <= 1'b0;
            prescaler_clear <= 1'b0;
            calendar_tick <= 1'b0;
        end else begin
            time_event <= tev_nxt;
            cal_field_reset <= fmt_chg | (mode_chg & ctl_nxt.mode);
            prescaler_clear <= mode_chg;
            calendar_tick <= ctl_r.mode & ~ctl_r.hold & src_edge[2];
        end
    end

    // Format reaches the calendar only in calendar mode: 0 binary, 1 decimal.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            format_decimal_select <= 1'b0;
        end else begin
            format_decimal_select <= ctl_nxt.fmt & ctl_nxt.mode;
        end
    end

    // In calendar mode the count hold overrides the individual prescaler holds.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_prescaler_run <= 1'b0;
            second_prescaler_run <= 1'b0;
        end else if (ctl_nxt.mode) begin
            first_prescaler_run <= ~ctl_nxt.hold;
            second_prescaler_run <= ~ctl_nxt.hold;
        end else begin
            first_prescaler_run <= ~first_prescaler_hold;
            second_prescaler_run <= ~second_prescaler_hold;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdy_r <= 1'b0;
        end else begin
            rdy_r <= ctl_nxt.mode & ~cal_busy;
        end
    end

    assign rdy_rise = ctl_nxt.mode & ~cal_busy & ~rdy_r;

    // Status bits are write-one-to-clear; a new event in the same cycle wins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_r <= rtcm_pkg::rtcm_irq_t'(`RTCM_IRQ_RST);
            mask_r <= rtcm_pkg::rtcm_irq_t'(`RTCM_IRQ_RST);
        end else begin
            if (wr_acc && paddr == `RTCM_STAT_OFS) begin
                stat_r <= (stat_r & ~rtcm_pkg::rtcm_irq_t'(pwdata[1:0])) |
                          rtcm_pkg::rtcm_irq_t'({rdy_rise, tev_nxt});
            end else begin
                stat_r <= stat_r | rtcm_pkg::rtcm_irq_t'({rdy_rise, tev_nxt});
            end
            if (wr_acc && paddr == `RTCM_MASK_OFS) begin
                mask_r <= rtcm_pkg::rtcm_irq_t'(pwdata[1:0]);
            end
        end
    end

    assign irq = |(stat_r & mask_r);

    always_comb begin
        rd_mux = 32'h0000_0000;
        pslverr = 1'b0;
        unique case (paddr)
            `RTCM_CTL1_OFS: rd_mux = {24'h00_0000, ctl_r.fmt, ctl_r.hold, ctl_r.mode, rdy_r,
                                      ctl_r.ssel, ctl_r.tev};
            `RTCM_COUNT_OFS: rd_mux = cnt_r;
            `RTCM_STAT_OFS: rd_mux = {30'h0000_0000, stat_r};
            `RTCM_MASK_OFS: rd_mux = {30'h0000_0000, mask_r};
            default: pslverr = psel & penable;
        endcase
    end

    // Read data is taken in the setup cycle, so it stands unchanged through the access phase.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_mux;
        end
    end

    fmt_ctr_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
        !ctl_r.mode |-> !format_decimal_select)
        else $error("format select active in counter mode");
    fmt_change_a: assert property (@(posedge pclk) disable iff (!presetn)
        fmt_chg |=> cal_field_reset ##1 !cal_field_reset || fmt_chg)
        else $error("format change did not reset fields");
    fmt_decimal_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctl_r.mode && ctl_r.fmt && !ctl_wr |=> format_decimal_select)
        else $error("decimal format not applied");
    hold_stops_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctl_r.hold && !cnt_wr && !mode_chg |=> $stable(cnt_r))
        else $error("counter moved while held");
    ctr_hold_psc_a: assert property (@(posedge pclk) disable iff (!presetn)
        $past(presetn) && !$past(ctl_nxt.mode) && $past(ctl_nxt.hold)
        && !$past(first_prescaler_hold) && !$past(second_prescaler_hold)
        |-> first_prescaler_run && second_prescaler_run)
        else $error("prescaler stopped by counter hold");
    cal_hold_psc_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctl_r.mode && ctl_r.hold && !ctl_wr |=> !first_prescaler_run && !second_prescaler_run
        && !calendar_tick)
        else $error("calendar hold did not stop prescalers");
    mode_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctl_wr && pwdata[`RTCM_MODE_BIT] |=> ctl_r.mode)
        else $error("calendar mode not selected");
    mode_cnt_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
        mode_chg |=> cnt_r == 32'h0000_0000)
        else $error("counter not cleared on mode switch");
    cal_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
        mode_chg && ctl_nxt.mode |=> cal_field_reset)
        else $error("fields not reset on calendar entry");
    psc_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        mode_chg && ctl_nxt.mode |=> prescaler_clear)
        else $error("prescalers not cleared on calendar entry");
    rdy_busy_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctl_r.mode && !ctl_wr && cal_busy |=> !rdy_r)
        else $error("read-safe set while values change");
    rdy_ctr_a: assert property (@(posedge pclk) disable iff (!presetn)
        !ctl_r.mode |-> !rdy_r)
        else $error("read-safe set in counter mode");
    aux_src_a: assert property (@(posedge pclk) disable iff (!presetn)
        !ctl_r.mode && !ctl_r.hold && ctl_r.ssel == 2'h0 && src_edge[0] && !cnt_wr
        && !mode_chg |=> cnt_r == $past(cnt_r) + 32'h0000_0001)
        else $error("auxiliary clock did not advance counter");
    cal_src_a: assert property (@(posedge pclk) disable iff (!presetn)
        calendar_tick |-> $past(src_edge[2]) && $past(ctl_r.mode))
        else $error("calendar ticked without second prescaler");
    ovf8_evt_a: assert property (@(posedge pclk) disable iff (!presetn)
        cnt_tick && ctl_r.tev == 2'h0 && cnt_r[7:0] == 8'hFF && !ctl_wr && !cnt_wr
        |=> time_event)
        else $error("8-bit overflow missed");
    ovf32_evt_a: assert property (@(posedge pclk) disable iff (!presetn)
        time_event && !$past(ctl_r.mode) && $past(ctl_r.tev) == 2'h3
        |-> cnt_r == 32'h0000_0000)
        else $error("32-bit event without overflow");
    cal_evt_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctl_r.mode && ctl_r.tev == 2'h1 && cal_evt.hour |=> time_event)
        else $error("hour event missed");
    same_val_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctl_wr && pwdata[`RTCM_MODE_BIT] == ctl_r.mode && pwdata[`RTCM_FMT_BIT] == ctl_r.fmt
        |=> !cal_field_reset && !prescaler_clear)
        else $error("rewrite of same value caused reset");
    ctr_entry_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
        mode_chg && !ctl_nxt.mode |=> prescaler_clear && cnt_r == 32'h0000_0000)
        else $error("counter entry did not clear counter and prescalers");
    mode_exit_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctl_wr && !pwdata[`RTCM_MODE_BIT] |=> !ctl_r.mode)
        else $error("counter mode not selected");
    cal_run_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctl_r.mode && !ctl_r.hold && !ctl_wr |=> first_prescaler_run && second_prescaler_run)
        else $error("calendar prescalers not running");
    psc_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        prescaler_clear |=> !prescaler_clear)
        else $error("prescaler clear longer than one cycle");
    rdy_safe_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctl_r.mode && !ctl_wr && !cal_busy |=> rdy_r)
        else $error("read-safe not set when values are stable");
    sub_src_a: assert property (@(posedge pclk) disable iff (!presetn)
        !ctl_r.mode && !ctl_r.hold && ctl_r.ssel == 2'h1 && src_edge[1] && !cnt_wr
        && !mode_chg |=> cnt_r == $past(cnt_r) + 32'h0000_0001)
        else $error("submain clock did not advance counter");
    psc_src_a: assert property (@(posedge pclk) disable iff (!presetn)
        !ctl_r.mode && !ctl_r.hold && ctl_r.ssel[1] && src_edge[2] && !cnt_wr
        && !mode_chg |=> cnt_r == $past(cnt_r) + 32'h0000_0001)
        else $error("second prescaler did not advance counter");
    cal_no_count_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctl_r.mode && !cnt_wr && !mode_chg |=> $stable(cnt_r))
        else $error("counter moved in calendar mode");
    no_ovf_evt_a: assert property (@(posedge pclk) disable iff (!presetn)
        !ctl_r.mode && !cnt_tick |=> !time_event)
        else $error("counter event without a tick");
    ovf24_evt_a: assert property (@(posedge pclk) disable iff (!presetn)
        cnt_tick && ctl_r.tev == 2'h2 && cnt_r[23:0] == 24'hFF_FFFF && !ctl_wr && !cnt_wr
        |=> time_event)
        else $error("24-bit overflow missed");
    noon_evt_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctl_r.mode && ctl_r.tev == 2'h3 && cal_evt.noon |=> time_event)
        else $error("noon event missed");
    no_cal_evt_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctl_r.mode && cal_evt == 4'h0 |=> !time_event)
        else $error("calendar event without a change");

    mode_switch_c: cover property (@(posedge pclk) disable iff (!presetn) mode_chg);
    cal_tick_c: cover property (@(posedge pclk) disable iff (!presetn) calendar_tick);
    ovf_evt_c: cover property (@(posedge pclk) disable iff (!presetn) !ctl_r.mode ##1 time_event);
    tev_irq_c: cover property (@(posedge pclk) disable iff (!presetn) time_event ##1 irq);
    rdy_rise_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(rdy_r));

endmodule

// ===== hdl/rtcm_params.svh
// Offsets, field positions, reset values and the operating rules of the RTC control block.
// Operation
// - Format select applies only in calendar mode.
// - Format change zeroes fields, day and month one.
// - Format zero binary, one decimal counting.
// - Hold resets set; counting only when cleared.
// - Counter-mode hold stops counter, prescalers keep running.
// - Calendar-mode hold stops calendar and both prescalers.
// - Mode resets to counter; one selects calendar.
// - Any mode switch resets counter registers.
// - Entering calendar resets fields, day, month one.
// - Entering calendar clears both prescaler counters.
// - Calendar read-safe low while values change.
// - Counter mode keeps read-safe at zero.
// - Source field picks auxiliary, submain, second prescaler.
// - Calendar always clocked from second prescaler.
// - Event select 00 fires on 8-bit overflow.
// - Values 01,10,11 fire on 16,24,32-bit overflow.
// - Calendar events: minute, hour, midnight, noon.
`ifndef RTCM_PARAMS_SVH
`define RTCM_PARAMS_SVH

`define RTCM_ADDR_W 12
`define RTCM_CTL1_OFS 12'h000
`define RTCM_COUNT_OFS 12'h004
`define RTCM_STAT_OFS 12'h008
`define RTCM_MASK_OFS 12'h00C

`define RTCM_FMT_BIT 7
`define RTCM_HOLD_BIT 6
`define RTCM_MODE_BIT 5
`define RTCM_RDY_BIT 4
`define RTCM_SSEL_LSB 2
`define RTCM_TEV_LSB 0

`define RTCM_CTL1_RST 8'h40
`define RTCM_COUNT_RST 32'h0000_0000
`define RTCM_IRQ_RST 2'h0

`define RTCM_IRQ_TEV_BIT 0
`define RTCM_IRQ_RDY_BIT 1

`define RTCM_SRC_AUX 2'h0
`define RTCM_SRC_SUB 2'h1
`define RTCM_TEV_8 2'h0
`define RTCM_TEV_16 2'h1
`define RTCM_TEV_24 2'h2
`define RTCM_TEV_32 2'h3

`endif

// ===== hdl/rtcm_pkg.sv
// Types shared by the RTC control block.
package rtcm_pkg;

    typedef struct packed {
        logic fmt;
        logic hold;
        logic mode;
        logic rdy;
        logic [1:0] ssel;
        logic [1:0] tev;
    } rtcm_ctl_t;

    typedef struct packed {
        logic minute;
        logic hour;
        logic midnight;
        logic noon;
    } rtcm_cal_evt_t;

    typedef struct packed {
        logic rdy;
        logic tev;
    } rtcm_irq_t;

endpackage

// ===== sim/rtcm_ctrl_tb.sv
// Self-checking testbench for the RTC control block, driven over APB.
`timescale 1ns/10ps
`include "rtcm_params.svh"
module rtcm_ctrl_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic [2:0] src = 3'h0;
    logic [1:0] psc_hold = 2'h0;
    rtcm_pkg::rtcm_cal_evt_t cal_evt = '0;
    logic cal_busy = 1'b0;
    logic fds, cfr, pclr, run0, run1, ctick, tev, irq;
    logic [32:0] exp_q[$];
    int fail_count = 0;
    int n_tests = 0;
    int nev = 0;
    int nfr = 0;
    int npc = 0;
    int ntk = 0;
    int e0, e1, e2, e3;
    logic [31:0] cnt, ones;

    always #2.5 pclk = ~pclk;

    rtcm_ctrl u_rtcm_ctrl (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .aux_clock_in(src[0]),
        .submain_clock_in(src[1]), .second_prescaler_out(src[2]),
        .first_prescaler_hold(psc_hold[0]), .second_prescaler_hold(psc_hold[1]),
        .cal_evt(cal_evt), .cal_busy(cal_busy), .format_decimal_select(fds),
        .cal_field_reset(cfr), .prescaler_clear(pclr), .first_prescaler_run(run0),
        .second_prescaler_run(run1), .calendar_tick(ctick), .time_event(tev), .irq(irq));

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd(input logic [11:0] a, input logic [32:0] exp);
        exp_q.push_back(exp);
        apb(a, 1'b0, 32'h0000_0000);
    endtask

    task automatic pulse(input int s, input int n);
        repeat (n) begin
            src[s] <= 1'b1;
            repeat (4) @(posedge pclk);
            src[s] <= 1'b0;
            repeat (4) @(posedge pclk);
        end
    endtask

    task automatic evt(input logic [3:0] v);
        @(posedge pclk);
        cal_evt <= rtcm_pkg::rtcm_cal_evt_t'(v);
        @(posedge pclk);
        cal_evt <= '0;
        repeat (3) @(posedge pclk);
    endtask

    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            check({pslverr, prdata}, exp_q.pop_front());
        end
        if (tev === 1'b1) nev++;
        if (cfr === 1'b1) nfr++;
        if (pclr === 1'b1) npc++;
        if (ctick === 1'b1) ntk++;
    end

    initial begin
        #200000;
        fail_count++;
        wrap_up();
    end

    initial begin
        void'($urandom(87));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(`RTCM_CTL1_OFS, {1'b0, 24'h0, `RTCM_CTL1_RST});
        rd(`RTCM_COUNT_OFS, 33'h0);
        rd(12'h0F0, 33'h1_0000_0000);
        psc_hold <= 2'h2;
        pulse(0, 1);
        check({run1, run0}, 2'h1);
        rd(`RTCM_COUNT_OFS, 33'h0);
        cnt = 32'h0;
        for (int t = 0; t < 4; t++) begin
            apb(`RTCM_CTL1_OFS, 1'b1, 32'(t << `RTCM_SSEL_LSB));
            e0 = $urandom_range(1, 3);
            e1 = $urandom_range(1, 3);
            e2 = $urandom_range(1, 3);
            pulse(0, e0);
            pulse(1, e1);
            pulse(2, e2);
            cnt += (t == 0) ? e0 : (t == 1) ? e1 : e2;
            rd(`RTCM_COUNT_OFS, {1'b0, cnt});
        end
        for (int t = 0; t < 4; t++) begin
            apb(`RTCM_CTL1_OFS, 1'b1, 32'(t));
            ones = (t == 3) ? 32'hFFFF_FFFF : (32'h1 << (8 * (t + 1))) - 32'h1;
            e0 = nev;
            apb(`RTCM_COUNT_OFS, 1'b1, ones);
            pulse(0, 1);
            check(nev - e0, 1);
            apb(`RTCM_COUNT_OFS, 1'b1, ones >> 8);
            pulse(0, 1);
            check(nev - e0, 1);
        end
        rd(`RTCM_STAT_OFS, 33'h1);
        check(irq, 0);
        apb(`RTCM_MASK_OFS, 1'b1, 32'h1);
        check(irq, 1);
        apb(`RTCM_STAT_OFS, 1'b1, 32'h1);
        check(irq, 0);
        apb(`RTCM_CTL1_OFS, 1'b1, 32'h40);
        pulse(0, 2);
        rd(`RTCM_COUNT_OFS, {1'b0, 32'h0100_0000});
        {e0, e1} = {nfr, npc};
        apb(`RTCM_CTL1_OFS, 1'b1, 32'h20);
        repeat (3) @(posedge pclk);
        check({16'(nfr - e0), 16'(npc - e1)}, {16'h1, 16'h1});
        rd(`RTCM_COUNT_OFS, 33'h0);
        check(fds, 0);
        check({run1, run0}, 2'h3);
        rd(`RTCM_CTL1_OFS, 33'h30);
        apb(`RTCM_CTL1_OFS, 1'b1, 32'h20);
        repeat (3) @(posedge pclk);
        check({16'(nfr - e0), 16'(npc - e1)}, {16'h1, 16'h1});
        e2 = ntk;
        pulse(0, 1);
        pulse(2, 2);
        check(ntk - e2, 2);
        cal_busy <= 1'b1;
        apb(`RTCM_CTL1_OFS, 1'b1, 32'h60);
        check({run1, run0}, 2'h0);
        rd(`RTCM_CTL1_OFS, 33'h60);
        cal_busy <= 1'b0;
        apb(`RTCM_CTL1_OFS, 1'b1, 32'hA0);
        repeat (3) @(posedge pclk);
        check(fds, 1);
        check({16'(nfr - e0), 16'(npc - e1)}, {16'h2, 16'h1});
        for (int t = 0; t < 4; t++) begin
            apb(`RTCM_CTL1_OFS, 1'b1, 32'hA0 | t);
            e3 = nev;
            evt(4'h8 >> ((t + 1) % 4));
            evt(4'h8 >> t);
            check(nev - e3, 1);
        end
        apb(`RTCM_CTL1_OFS, 1'b1, 32'h80);
        repeat (3) @(posedge pclk);
        check(fds, 0);
        check(npc - e1, 2);
        rd(`RTCM_CTL1_OFS, 33'h80);
        wrap_up();
    end
endmodule
